// ### rtl/itm_interval_timer.sv
// Function
// - the timeout flag goes to one on the edge where a count of one reloads.
// - with the interrupt enable at one a timeout raises the request, else not.
// - a write to the status word clears the timeout flag and the request, unless a timeout lands in the same cycle.
// - a control write of 0b0111 starts, selects continuous and enables irq.
// - start value comes as low then high halfword; 0x190000 gives ~33 ms.
// - the count steps down each clock, reloads at one, stops unless continuous.
// - a one on start begins counting, a one on stop halts with count held.
// - the running bit shows active counting and status writes never touch it.
// - a write to the low snapshot word captures the live count for readback.
module itm_interval_timer #(
    parameter logic [31:0] DEFAULT_START = 32'(itm_pkg::DEFAULT_START_CYCLES)
) (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic ctrl_wr_in,
    input wire itm_pkg::itm_ctrl_t ctrl_in,
    input wire logic status_wr_in,
    input wire logic start_lo_wr_in,
    input wire logic start_hi_wr_in,
    input wire logic [itm_pkg::HALF_W-1:0] start_half_in,
    input wire logic snap_wr_in,
    output itm_pkg::itm_ctrl_t ctrl_out,
    output itm_pkg::itm_status_t status_out,
    output itm_pkg::itm_word_t start_out,
    output itm_pkg::itm_word_t snapshot_out,
    output logic timer_irq_out
);
    import itm_pkg::*;

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    itm_state_t state_q;
    itm_state_t state_d;
    logic continuous_reload_q;
    logic continuous_reload_d;
    logic irq_en_q;
    logic irq_en_d;
    logic flag_q;
    logic flag_d;
    itm_word_t start_q;
    itm_word_t start_d;
    logic start_init_q;
    logic start_init_d;
    itm_word_t snap_q;
    itm_word_t snap_d;

    logic run;
    logic load;
    logic wrap;
    logic [COUNT_W-1:0] count;
    logic start_req;
    logic stop_req;

    assign run = (state_q == ITM_COUNT);

    // ----------------------------------------------------------------
    // counter
    // ----------------------------------------------------------------
    // writing either half of the start value also reloads the count,
    // so a new period takes effect without waiting for the old one
    assign load = start_lo_wr_in || start_hi_wr_in;

    itm_down_counter u_counter (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .rst_value_in(DEFAULT_START),
        .run_in(run),
        .load_in(load),
        .load_value_in(start_d),
        .count_out(count),
        .wrap_out(wrap)
    );

    // ----------------------------------------------------------------
    // start value halves
    // ----------------------------------------------------------------
    // a half write merges with the other half held in the register
    always_comb begin
        start_d = start_q;
        start_init_d = 1'b1;
        if (!start_init_q) begin
            start_d = DEFAULT_START;
        end
        if (start_lo_wr_in) begin
            start_d.lo = start_half_in;
        end
        if (start_hi_wr_in) begin
            start_d.hi = start_half_in;
        end
    end

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            start_q <= '0;
            start_init_q <= 1'b0;
        end else begin
            start_q <= start_d;
            start_init_q <= start_init_d;
        end
    end

    // ----------------------------------------------------------------
    // control decode
    // ----------------------------------------------------------------
    // stop wins over start in one write, so a stray pair of bits
    // can never leave the timer running
    assign stop_req = ctrl_wr_in && ctrl_in.stop;
    assign start_req = ctrl_wr_in && ctrl_in.start && !ctrl_in.stop;

    // ----------------------------------------------------------------
    // control bits
    // ----------------------------------------------------------------
    always_comb begin
        continuous_reload_d = continuous_reload_q;
        irq_en_d = irq_en_q;
        if (ctrl_wr_in) begin
            continuous_reload_d = ctrl_in.continuous_reload;
            irq_en_d = ctrl_in.timeout_irq_enable;
        end
    end

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            continuous_reload_q <= RST_CONTINUOUS_RELOAD;
            irq_en_q <= RST_IRQ_EN;
        end else begin
            continuous_reload_q <= continuous_reload_d;
            irq_en_q <= irq_en_d;
        end
    end

    // ----------------------------------------------------------------
    // run state
    // ----------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        case (state_q)
            ITM_IDLE: begin
                if (start_req) begin
                    state_d = ITM_COUNT;
                end
            end
            ITM_COUNT: begin
                if (stop_req) begin
                    // count holds in the counter while idle
                    state_d = ITM_IDLE;
                end else if (wrap && !continuous_reload_q) begin
                    state_d = ITM_IDLE;
                end
            end
            default: begin
                state_d = ITM_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            state_q <= ITM_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // ----------------------------------------------------------------
    // timeout flag
    // ----------------------------------------------------------------
    always_comb begin
        flag_d = flag_q;
        if (status_wr_in) begin
            flag_d = 1'b0;
        end
        // a timeout in the clearing cycle is kept: set beats clear
        if (wrap) begin
            flag_d = 1'b1;
        end
    end

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            flag_q <= RST_FLAG;
        end else begin
            flag_q <= flag_d;
        end
    end

    // ----------------------------------------------------------------
    // snapshot
    // ----------------------------------------------------------------
    // the capture takes the count from before the write edge
    always_comb begin
        snap_d = snap_q;
        if (snap_wr_in) begin
            snap_d = count;
        end
    end

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            snap_q <= RST_SNAPSHOT;
        end else begin
            snap_q <= snap_d;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    // stop and start are write-only actions and read back as zero
    assign ctrl_out.stop = 1'b0;
    assign ctrl_out.start = 1'b0;
    assign ctrl_out.continuous_reload = continuous_reload_q;
    assign ctrl_out.timeout_irq_enable = irq_en_q;
    assign status_out.running = run;
    assign status_out.timeout_flag = flag_q;
    assign start_out = start_q;
    assign snapshot_out = snap_q;
    // level request, dropped only by clearing the flag or the enable
    assign timer_irq_out = flag_q && irq_en_q;

endmodule : itm_interval_timer

// ### common/itm_pkg.sv
package itm_pkg;

    // ----------------------------------------------------------------
    // clock and timing
    // ----------------------------------------------------------------
    localparam int unsigned CLK_HZ = 50_000_000;
    localparam int unsigned DEFAULT_PERIOD_MS = 125;
    // default reload count: clock rate times default period
    localparam longint unsigned DEFAULT_START_CYCLES =
        (64'(CLK_HZ) * 64'(DEFAULT_PERIOD_MS)) / 64'd1000;

    // ----------------------------------------------------------------
    // widths
    // ----------------------------------------------------------------
    localparam int unsigned HALF_W = 16;
    localparam int unsigned COUNT_W = 32;

    // ----------------------------------------------------------------
    // control word bit positions
    // ----------------------------------------------------------------
    localparam int unsigned CTRL_IRQ_EN_BIT = 0;
    localparam int unsigned CTRL_CONTINUOUS_RELOAD_BIT = 1;
    localparam int unsigned CTRL_START_BIT = 2;
    localparam int unsigned CTRL_STOP_BIT = 3;
    localparam int unsigned CTRL_W = 4;

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic RST_IRQ_EN = 1'h0;
    localparam logic RST_CONTINUOUS_RELOAD = 1'h0;
    localparam logic RST_FLAG = 1'h0;
    localparam logic [COUNT_W-1:0] RST_SNAPSHOT = 32'h0000_0000;

    // ----------------------------------------------------------------
    // carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic stop;
        logic start;
        logic continuous_reload;
        logic timeout_irq_enable;
    } itm_ctrl_t;

    typedef struct packed {
        logic [HALF_W-1:0] hi;
        logic [HALF_W-1:0] lo;
    } itm_word_t;

    typedef struct packed {
        logic running;
        logic timeout_flag;
    } itm_status_t;

    typedef enum logic {
        ITM_IDLE,
        ITM_COUNT
    } itm_state_t;

endpackage : itm_pkg

// ### rtl/itm_down_counter.sv
module itm_down_counter (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic [itm_pkg::COUNT_W-1:0] rst_value_in,
    input wire logic run_in,
    input wire logic load_in,
    input wire logic [itm_pkg::COUNT_W-1:0] load_value_in,
    output logic [itm_pkg::COUNT_W-1:0] count_out,
    output logic wrap_out
);
    import itm_pkg::*;

    logic [COUNT_W-1:0] count_q;
    logic [COUNT_W-1:0] count_d;
    logic init_q;
    logic init_d;

    // ----------------------------------------------------------------
    // count arithmetic
    // ----------------------------------------------------------------
    function automatic logic at_end(input logic [COUNT_W-1:0] v);
        // a count of one reloads on this edge instead of stepping to zero; zero itself
        // also ends so a zero start value cannot hang the counter
        at_end = (v <= 32'h0000_0001);
    endfunction : at_end

    assign wrap_out = run_in && !load_in && at_end(count_q);
    assign count_out = count_q;

    always_comb begin
        count_d = count_q;
        init_d = 1'b1;
        if (!init_q) begin
            // reset value is a port, so it is taken after release
            count_d = rst_value_in;
        end else if (load_in) begin
            count_d = load_value_in;
        end else if (run_in) begin
            if (at_end(count_q)) begin
                count_d = load_value_in;
            end else begin
                count_d = count_q - 32'h0000_0001;
            end
        end
    end

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            count_q <= 32'h0000_0000;
            init_q <= 1'b0;
        end else begin
            count_q <= count_d;
            init_q <= init_d;
        end
    end

endmodule : itm_down_counter

// ### tb/itm_interval_timer_checker.sv
module itm_interval_timer_checker (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic ctrl_wr_in,
    input wire itm_pkg::itm_ctrl_t ctrl_in,
    input wire logic status_wr_in,
    input wire logic start_lo_wr_in,
    input wire logic start_hi_wr_in,
    input wire logic [itm_pkg::HALF_W-1:0] start_half_in,
    input wire logic snap_wr_in,
    input wire itm_pkg::itm_ctrl_t ctrl_out,
    input wire itm_pkg::itm_status_t status_out,
    input wire itm_pkg::itm_word_t start_out,
    input wire itm_pkg::itm_word_t snapshot_out,
    input wire logic timer_irq_out
);
    timeunit 1ns;
    timeprecision 1ps;
    import itm_pkg::*;
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);
    // idle only: a timeout on the same edge could otherwise set the flag
    sequence s_clear;
        status_wr_in && !status_out.running;
    endsequence
    sequence s_go;
        ctrl_wr_in && ctrl_in.start && !ctrl_in.stop && !status_out.running;
    endsequence
    property p_irq;
        timer_irq_out == (status_out.timeout_flag && ctrl_out[0]);
    endproperty
    property p_clear;
        s_clear |=> !status_out.timeout_flag && !timer_irq_out;
    endproperty
    property p_flag_rise;
        $rose(status_out.timeout_flag) |-> $past(status_out.running);
    endproperty
    property p_start;
        s_go |=> status_out.running;
    endproperty
    property p_stop;
        ctrl_wr_in && ctrl_in.stop |=> !status_out.running;
    endproperty
    property p_ctrl_rb;
        ctrl_wr_in |=> ctrl_out[3:2] == 2'h0
            && ctrl_out[1:0] == $past(ctrl_in[1:0]);
    endproperty
    property p_run_kept;
        status_wr_in && !ctrl_wr_in && ctrl_out.continuous_reload
            |=> $stable(status_out.running);
    endproperty
    property p_oneshot;
        $fell(status_out.running) && !$past(ctrl_wr_in)
            |-> status_out.timeout_flag;
    endproperty
    property p_start_lo;
        start_lo_wr_in && !$past(sys_rst_in)
            |=> start_out.lo == $past(start_half_in);
    endproperty
    a_irq: assert property (p_irq) else $error("irq level wrong");
    a_clear: assert property (p_clear) else $error("no clear");
    a_flag_rise: assert property (p_flag_rise) else $error("no run");
    a_start: assert property (p_start) else $error("no start");
    a_stop: assert property (p_stop) else $error("no stop");
    a_ctrl_rb: assert property (p_ctrl_rb) else $error("ctrl rb");
    a_run_kept: assert property (p_run_kept) else $error("run moved");
    a_oneshot: assert property (p_oneshot) else $error("bad halt");
    a_start_lo: assert property (p_start_lo) else $error("start lo");
endmodule : itm_interval_timer_checker

bind itm_interval_timer itm_interval_timer_checker u_chk (.clk_in,
    .sys_rst_in, .ctrl_wr_in, .ctrl_in, .status_wr_in, .start_lo_wr_in,
    .start_hi_wr_in, .start_half_in, .snap_wr_in, .ctrl_out, .status_out,
    .start_out, .snapshot_out, .timer_irq_out);

// ### tb/tb_top.sv
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import itm_pkg::*;
    logic clk_in, sys_rst_in, ctrl_wr_in, status_wr_in, snap_wr_in;
    logic start_lo_wr_in, start_hi_wr_in, timer_irq_out;
    logic [15:0] start_half_in;
    itm_ctrl_t ctrl_in, ctrl_out;
    itm_status_t status_out;
    itm_word_t start_out, snapshot_out;
    int errors = 0;
    int num_checks = 0;
    // ------------------------------------------------------------
    // dut, clock, tasks
    // ------------------------------------------------------------
    // short default period keeps the run brief
    itm_interval_timer #(.DEFAULT_START(32'h14)) u_dut (.clk_in,
        .sys_rst_in, .ctrl_wr_in, .ctrl_in, .status_wr_in, .start_lo_wr_in,
        .start_hi_wr_in, .start_half_in, .snap_wr_in, .ctrl_out,
        .status_out, .start_out, .snapshot_out, .timer_irq_out);
    always #10 clk_in = ~clk_in;
    task automatic chk(input string nm, input logic [31:0] e, g);
        num_checks++;
        if (g !== e) begin
            errors++;
            $display("CHECK FAILED %s exp %h got %h", nm, e, g);
        end
    endtask : chk
    task automatic wr_ctrl(input logic [3:0] v);
        @(posedge clk_in);
        ctrl_wr_in <= 1'h1;
        ctrl_in <= itm_ctrl_t'(v);
        @(posedge clk_in);
        ctrl_wr_in <= 1'h0;
    endtask : wr_ctrl
    task automatic wr_start(input logic [15:0] lo, hi);
        @(posedge clk_in);
        start_lo_wr_in <= 1'h1;
        start_half_in <= lo;
        @(posedge clk_in);
        start_lo_wr_in <= 1'h0;
        start_hi_wr_in <= 1'h1;
        start_half_in <= hi;
        @(posedge clk_in);
        start_hi_wr_in <= 1'h0;
        #1;
    endtask : wr_start
    task automatic wr_status();
        @(posedge clk_in);
        status_wr_in <= 1'h1;
        @(posedge clk_in);
        status_wr_in <= 1'h0;
        #1;
    endtask : wr_status
    task automatic snap();
        @(posedge clk_in);
        snap_wr_in <= 1'h1;
        @(posedge clk_in);
        snap_wr_in <= 1'h0;
        #1;
    endtask : snap
    task automatic wait_flag();
        for (int n = 0; n < 40 && status_out.timeout_flag !== 1'h1; n++) begin
            @(posedge clk_in);
            #1;
        end
    endtask : wait_flag
    task automatic final_report();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : final_report
    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        repeat (3000) @(posedge clk_in);
        errors++;
        final_report();
    end
    initial begin
        {clk_in, ctrl_wr_in, status_wr_in, snap_wr_in} = 4'h0;
        {start_lo_wr_in, start_hi_wr_in, start_half_in} = 18'h0;
        ctrl_in = itm_ctrl_t'(4'h0);
        sys_rst_in = 1'h1;
        repeat (5) @(posedge clk_in);
        sys_rst_in <= 1'h0;
        repeat (2) @(posedge clk_in);
        #1;
        chk("start", 32'h14, start_out);
        chk("irq", 1'h0, timer_irq_out);
        wr_start(16'h0000, 16'h0019);
        chk("start", 32'h0019_0000, start_out);
        wr_start(16'h0008, 16'h0000);
        chk("start", 32'h8, start_out);
        wr_ctrl(4'h7);
        #1;
        chk("ctrl", 4'h3, ctrl_out);
        chk("run", 1'h1, status_out.running);
        repeat (7) @(posedge clk_in);
        #1;
        chk("flag", 1'h0, status_out.timeout_flag);
        @(posedge clk_in);
        #1;
        chk("flag", 1'h1, status_out.timeout_flag);
        chk("irq", 1'h1, timer_irq_out);
        wr_status();
        chk("flag", 1'h0, status_out.timeout_flag);
        chk("irq", 1'h0, timer_irq_out);
        chk("run", 1'h1, status_out.running);
        repeat (5) @(posedge clk_in);
        #1;
        chk("flag", 1'h0, status_out.timeout_flag);
        @(posedge clk_in);
        #1;
        chk("flag", 1'h1, status_out.timeout_flag);
        $display("test period done");
        wr_ctrl(4'h2);
        #1;
        chk("irq", 1'h0, timer_irq_out);
        wr_status();
        wait_flag();
        chk("flag", 1'h1, status_out.timeout_flag);
        chk("irq", 1'h0, timer_irq_out);
        wr_ctrl(4'h8);
        #1;
        chk("run", 1'h0, status_out.running);
        wr_start(16'h0005, 16'h0000);
        snap();
        chk("snap", 32'h5, snapshot_out);
        wr_ctrl(4'h4);
        #1;
        snap();
        chk("snap", 32'h4, snapshot_out);
        $display("test stop snapshot done");
        wr_ctrl(4'h9);
        wr_status();
        wr_ctrl(4'h5);
        wait_flag();
        chk("run", 1'h0, status_out.running);
        chk("irq", 1'h1, timer_irq_out);
        wr_status();
        chk("run", 1'h0, status_out.running);
        chk("flag", 1'h0, status_out.timeout_flag);
        $display("test one shot done");
        final_report();
    end
endmodule : tb_top
